// ==== design/umc_mode_cfg.sv ====
// UART channel mode selection, feature gating and clock configuration
// ==========================================================================
`timescale 1ns/1ns
`default_nettype none
`include "umc_defs.svh"

module umc_mode_cfg
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Channel register port
  input  wire logic [2:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_wdata,
  output var  logic [7:0]            reg_rdata,
  // Pins
  input  wire logic                  fifo_depth_select_pin,
  input  wire logic                  ring_indicate_input,
  input  wire logic                  dsr_input,
  input  wire logic                  dtr_input,
  // Datapath status
  input  wire logic [7:0]            rx_fill_level,
  input  wire logic [7:0]            tx_fill_level,
  input  wire logic [7:0]            flow_state,
  // Mode outputs
  output var  umc_pkg::umc_mode_t    mode,
  output var  logic [7:0]            fifo_depth,
  output var  logic                  feat_750,
  output var  logic                  feat_enh,
  output var  logic                  feat_950,
  output var  logic                  trig_from_regs,
  output var  logic [7:0]            rx_trigger_level,
  output var  logic [7:0]            tx_trigger_level,
  output var  logic [7:0]            flow_low_threshold,
  output var  logic [7:0]            flow_high_threshold,
  output var  logic [1:0]            fifo_trig_sel,
  output var  logic                  tx_disable,
  output var  logic                  rx_disable,
  output var  logic                  rs485_enable,
  output var  logic                  dsr_flow_enable,
  output var  logic                  nine_bit_enable,
  output var  logic                  soft_reset,
  // Clocking outputs
  output var  logic                  baud_tick,
  output var  logic [4:0]            samples_per_bit,
  output var  umc_pkg::umc_clk_src_t tx_clk_src,
  output var  umc_pkg::umc_clk_src_t rx_clk_src,
  output var  logic                  tx_ext_clk,
  output var  logic                  rx_ext_clk
);

  import umc_pkg::*;

  // ========================================================================
  // Register state
  logic [7:0] fifo_control_reg;
  logic [7:0] line_control_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] additional_control_reg;
  logic [7:0] baud_prescale_divider;
  logic [7:0] external_clock_source_select;
  logic [7:0] sample_clock_count;
  logic [7:0] scratch_index;
  logic [7:0] csr_nine_bit;
  logic [7:0] next_fcr;
  logic [7:0] next_lcr;
  logic [7:0] next_efr;
  logic [7:0] next_acr;
  logic [7:0] next_cpr;
  logic [7:0] next_cks;
  logic [7:0] next_tcr;
  logic [7:0] next_spr;
  logic [7:0] next_csr;
  logic [7:0] next_rtl;
  logic [7:0] next_ttl;
  logic [7:0] next_fcl;
  logic [7:0] next_fch;
  logic       next_srst;
  logic [7:0] next_rdata;
  logic       key_open;
  logic       icr_write;
  logic       ring_s;
  logic       dsr_s;
  logic       dtr_s;
  logic       depth_pin_s;

  // Enhanced set stays open while line control holds the unlock key
  assign key_open  = (line_control_reg == `UMC_LCR_KEY);
  // Indexed set is written through the data window when enabled
  // The control slot itself is writable whenever DLAB is clear, else the set could never
  // be opened after reset; a data write while the index rests there lands
  assign icr_write = reg_wr && (reg_addr == `UMC_OFS_THR)
                     && (additional_control_reg[`UMC_ACR_ICR]
                         || (scratch_index == `UMC_IDX_ACR))
                     && !line_control_reg[`UMC_LCR_DLAB];

  // ========================================================================
  // Write decode
  always_comb
  begin
    next_fcr  = fifo_control_reg;
    next_lcr  = line_control_reg;
    next_efr  = enhanced_feature_reg;
    next_acr  = additional_control_reg;
    next_cpr  = baud_prescale_divider;
    next_cks  = external_clock_source_select;
    next_tcr  = sample_clock_count;
    next_spr  = scratch_index;
    next_csr  = csr_nine_bit;
    next_rtl  = rx_trigger_level;
    next_ttl  = tx_trigger_level;
    next_fcl  = flow_low_threshold;
    next_fch  = flow_high_threshold;
    next_srst = 1'b0;
    if (reg_wr && key_open && (reg_addr == `UMC_OFS_EFR))
    begin
      next_efr = reg_wdata;
    end
    else if (reg_wr && (reg_addr == `UMC_OFS_FCR))
    begin
      next_fcr = reg_wdata;
      // Depth bit is guarded by latch access
      if (!line_control_reg[`UMC_LCR_DLAB])
        next_fcr[`UMC_FCR_DEPTH] = fifo_control_reg[`UMC_FCR_DEPTH];
    end
    else if (reg_wr && (reg_addr == `UMC_OFS_LCR))
    begin
      // Key only sets the latch bit, format bits stay put
      if (reg_wdata == `UMC_LCR_KEY)
        next_lcr = {1'b1, line_control_reg[6:0]};
      else
        next_lcr = reg_wdata;
    end
    else if (reg_wr && (reg_addr == `UMC_OFS_SPR))
    begin
      next_spr = reg_wdata;
    end
    else if (icr_write)
    begin
      if (scratch_index == `UMC_IDX_ACR)
        next_acr = reg_wdata;
      else if (scratch_index == `UMC_IDX_CPR)
        next_cpr = reg_wdata;
      else if (scratch_index == `UMC_IDX_CKS)
        next_cks = reg_wdata;
      else if (scratch_index == `UMC_IDX_TCR)
        next_tcr = reg_wdata;
      else if (scratch_index == `UMC_IDX_TTL)
        next_ttl = reg_wdata;
      else if (scratch_index == `UMC_IDX_RTL)
        next_rtl = reg_wdata;
      else if (scratch_index == `UMC_IDX_FCL)
        next_fcl = reg_wdata;
      else if (scratch_index == `UMC_IDX_FCH)
        next_fch = reg_wdata;
      else if (scratch_index == `UMC_IDX_CSR)
        // Zero written to the control slot is a software reset
        if (reg_wdata == `UMC_SRST_KEY)
          next_srst = 1'b1;
        else
          next_csr = reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fifo_control_reg             <= 8'h00;
      line_control_reg             <= 8'h00;
      enhanced_feature_reg         <= 8'h00;
      additional_control_reg       <= 8'h00;
      baud_prescale_divider        <= `UMC_CPR_RESET;
      external_clock_source_select <= 8'h00;
      sample_clock_count           <= `UMC_TCR_RESET;
      scratch_index                <= 8'h00;
      csr_nine_bit                 <= 8'h00;
      rx_trigger_level             <= 8'h00;
      tx_trigger_level             <= 8'h00;
      flow_low_threshold           <= 8'h00;
      flow_high_threshold          <= 8'h00;
      soft_reset                   <= 1'b0;
    end
    else
    begin
      fifo_control_reg             <= next_fcr;
      line_control_reg             <= next_lcr;
      enhanced_feature_reg         <= next_efr;
      additional_control_reg       <= next_acr;
      baud_prescale_divider        <= next_cpr;
      external_clock_source_select <= next_cks;
      sample_clock_count           <= next_tcr;
      scratch_index                <= next_spr;
      csr_nine_bit                 <= next_csr;
      rx_trigger_level             <= next_rtl;
      tx_trigger_level             <= next_ttl;
      flow_low_threshold           <= next_fcl;
      flow_high_threshold          <= next_fch;
      soft_reset                   <= next_srst;
    end
  end

  // ========================================================================
  // Mode and feature decode, purely combinational on current bits
  always_comb
  begin
    feat_750 = 1'b0;
    feat_enh = 1'b0;
    feat_950 = 1'b0;
    if (!fifo_control_reg[`UMC_FCR_EN])
    begin
      mode       = UMC_MODE_BYTE;
      fifo_depth = `UMC_DEPTH_BYTE;
    end
    else if (enhanced_feature_reg[`UMC_EFR_ENH])
    begin
      mode       = UMC_MODE_ENH;
      fifo_depth = `UMC_DEPTH_DEEP;
      feat_enh   = 1'b1;
      feat_950   = 1'b1;
    end
    else if (fifo_control_reg[`UMC_FCR_DEPTH])
    begin
      mode       = UMC_MODE_750;
      fifo_depth = `UMC_DEPTH_DEEP;
      feat_750   = 1'b1;
    end
    else if (depth_pin_s)
    begin
      mode       = UMC_MODE_EXT_PIN;
      fifo_depth = `UMC_DEPTH_DEEP;
    end
    else
    begin
      mode       = UMC_MODE_BASIC;
      fifo_depth = `UMC_DEPTH_BASIC;
    end
  end

  // 950 extras each need enhanced mode and their own control bit
  assign trig_from_regs  = feat_950 && additional_control_reg[`UMC_ACR_TRIG];
  assign fifo_trig_sel   = trig_from_regs ? 2'b00 : fifo_control_reg[7:6];
  assign tx_disable      = feat_950 && additional_control_reg[`UMC_ACR_TX_DIS];
  assign rx_disable      = feat_950 && additional_control_reg[`UMC_ACR_RX_DIS];
  assign rs485_enable    = feat_950 && additional_control_reg[`UMC_ACR_RS485];
  assign dsr_flow_enable = feat_950
                           && additional_control_reg[`UMC_ACR_DSR_FLOW];
  assign nine_bit_enable = feat_950 && csr_nine_bit[0];

  // ========================================================================
  // Clocking: prescaler, sample count, external clock sources
  umc_prescaler u_presc
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .divide   (baud_prescale_divider),
    .tick     (baud_tick)
  );

  always_comb
  begin
    if (sample_clock_count[3:0] < `UMC_SAMPLES_MIN)
      samples_per_bit = `UMC_SAMPLES_DFLT;
    else
      samples_per_bit = {1'b0, sample_clock_count[3:0]};
  end

  umc_sync2 u_sync_ri
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   (ring_indicate_input),
    .pin_sync (ring_s)
  );

  umc_sync2 u_sync_dsr
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   (dsr_input),
    .pin_sync (dsr_s)
  );

  umc_sync2 u_sync_dtr
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   (dtr_input),
    .pin_sync (dtr_s)
  );

  // The depth strap is a pin too, so it is synchronised like the rest
  umc_sync2 u_sync_sel
  (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   (fifo_depth_select_pin),
    .pin_sync (depth_pin_s)
  );

  // Bits 1:0 pick transmit source, bit 2 picks receive from data-set-ready
  always_comb
  begin
    rx_clk_src = external_clock_source_select[2] ? UMC_CLK_DSR
                                                 : UMC_CLK_INTERNAL;
    rx_ext_clk = external_clock_source_select[2] && dsr_s;
    if (external_clock_source_select[1:0] == 2'b01)
    begin
      tx_clk_src = UMC_CLK_RING;
      tx_ext_clk = ring_s;
    end
    else if (external_clock_source_select[1:0] == 2'b10)
    begin
      tx_clk_src = UMC_CLK_READY;
      tx_ext_clk = dtr_s;
    end
    else
    begin
      tx_clk_src = UMC_CLK_INTERNAL;
      tx_ext_clk = 1'b0;
    end
  end

  // ========================================================================
  // Read decode, registered
  always_comb
  begin
    next_rdata = 8'h00;
    if (!reg_rd)
      next_rdata = reg_rdata;
    else if (reg_addr == `UMC_OFS_LCR)
      next_rdata = line_control_reg;
    else if (key_open && (reg_addr == `UMC_OFS_EFR))
      next_rdata = enhanced_feature_reg;
    else if (reg_addr == `UMC_OFS_SPR)
      next_rdata = scratch_index;
    else if ((reg_addr == `UMC_OFS_THR)
             && additional_control_reg[`UMC_ACR_950])
    begin
      if (scratch_index == `UMC_IDX_ACR)
        next_rdata = additional_control_reg;
      else if (scratch_index == `UMC_IDX_CPR)
        next_rdata = baud_prescale_divider;
      else if (scratch_index == `UMC_IDX_CKS)
        next_rdata = external_clock_source_select;
      else if (scratch_index == `UMC_IDX_TCR)
        next_rdata = sample_clock_count;
      else if (scratch_index == `UMC_IDX_ID1)
        next_rdata = `UMC_ID_BYTE0;
      else if (scratch_index == `UMC_IDX_ID2)
        next_rdata = `UMC_ID_BYTE1;
      else if (scratch_index == `UMC_IDX_ID3)
        next_rdata = `UMC_ID_BYTE2;
      else if (scratch_index == `UMC_IDX_REV)
        next_rdata = `UMC_ID_BYTE3;
      else if (scratch_index == `UMC_IDX_CSR)
        next_rdata = fifo_control_reg;
      else if (scratch_index == `UMC_IDX_RFL)
        next_rdata = rx_fill_level;
      else if (scratch_index == `UMC_IDX_TFL)
        next_rdata = tx_fill_level;
      else if (scratch_index == `UMC_IDX_ASR)
        next_rdata = flow_state;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= next_rdata;
  end

endmodule
`default_nettype wire

// ==== design/umc_defs.svh ====
// Offsets, field positions, reset values and timing counts of the mode block
`ifndef UMC_DEFS_SVH
`define UMC_DEFS_SVH

// ==========================================================================
// Channel register offsets (3-bit channel window)
`define UMC_OFS_THR        3'h0
`define UMC_OFS_FCR        3'h2
`define UMC_OFS_LCR        3'h3
`define UMC_OFS_SPR        3'h7
// Indexed set offsets (written through the THR data window, index in SPR)
`define UMC_IDX_ACR        8'h00
`define UMC_IDX_CPR        8'h01
`define UMC_IDX_CKS        8'h02
`define UMC_IDX_TCR        8'h03
`define UMC_IDX_TTL        8'h04
`define UMC_IDX_RTL        8'h05
`define UMC_IDX_FCL        8'h06
`define UMC_IDX_FCH        8'h07
`define UMC_IDX_ID1        8'h08
`define UMC_IDX_ID2        8'h09
`define UMC_IDX_ID3        8'h0a
`define UMC_IDX_REV        8'h0b
`define UMC_IDX_CSR        8'h0c
`define UMC_IDX_RFL        8'h0d
`define UMC_IDX_TFL        8'h0e
`define UMC_IDX_ASR        8'h0f
// Enhanced register set offset when LINE_CONTROL_REG holds the unlock key
`define UMC_OFS_EFR        3'h2
`define UMC_LCR_KEY        8'hbf

// ==========================================================================
// Field positions
`define UMC_FCR_EN         0
`define UMC_FCR_DEPTH      5
`define UMC_LCR_DLAB       7
`define UMC_EFR_ENH        4
`define UMC_ACR_TRIG       5
`define UMC_ACR_ICR        6
`define UMC_ACR_950        7
`define UMC_ACR_DSR_FLOW   3
`define UMC_ACR_RS485      4
`define UMC_ACR_RX_DIS     0
`define UMC_ACR_TX_DIS     1

// ==========================================================================
// Reset values and depths
`define UMC_CPR_RESET      8'h20
`define UMC_TCR_RESET      8'h00
`define UMC_SAMPLES_DFLT   5'h10
`define UMC_SAMPLES_MIN    4'h4
`define UMC_DEPTH_BYTE     8'h01
`define UMC_DEPTH_BASIC    8'h10
`define UMC_DEPTH_DEEP     8'h80
`define UMC_SRST_KEY       8'h00
// Arbitrary identification bytes, not tied to any part
`define UMC_ID_BYTE0       8'h5a
`define UMC_ID_BYTE1       8'ha5
`define UMC_ID_BYTE2       8'h3c
`define UMC_ID_BYTE3       8'hc3

`endif

// ==== design/umc_pkg.sv ====
// Types shared by the mode and clock configuration block
package umc_pkg;

  typedef enum logic [2:0] {
    UMC_MODE_BYTE,
    UMC_MODE_BASIC,
    UMC_MODE_EXT_PIN,
    UMC_MODE_750,
    UMC_MODE_ENH
  } umc_mode_t;

  typedef enum logic [1:0] {
    UMC_CLK_INTERNAL,
    UMC_CLK_RING,
    UMC_CLK_READY,
    UMC_CLK_DSR
  } umc_clk_src_t;

endpackage

// ==== design/umc_sync2.sv ====
// Two-flop synchroniser for one pin level
`timescale 1ns/1ns
`default_nettype none

module umc_sync2
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Level
  input  wire logic pin_in,
  output var  logic pin_sync
);

  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb
  begin
    next_meta = pin_in;
    next_sync = meta;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta     <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      meta     <= next_meta;
      pin_sync <= next_sync;
    end
  end

endmodule
`default_nettype wire

// ==== design/umc_prescaler.sv ====
// Fractional M+N/8 prescaler producing a one-cycle baud enable
`timescale 1ns/1ns
`default_nettype none

module umc_prescaler
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Divide setting, M in [7:3], N in [2:0]
  input  wire logic [7:0] divide,
  // Enable out
  output var  logic       tick
);

  // Accumulate in eighths: step 8 per clock, wrap at M*8+N
  logic [8:0] acc;
  logic [8:0] next_acc;
  logic       next_tick;
  logic [8:0] limit;
  logic [8:0] sum;

  always_comb
  begin
    // M of zero is treated as a divide of exactly one, N ignored, so the divider never stalls
    limit = (divide[7:3] == 5'h00) ? 9'h008 : {1'b0, divide};
    sum = acc + 9'h008;
    // A smaller divide written mid-count leaves acc past the new limit;
    // restart the count there instead of ticking on every clock
    if (acc >= limit)
    begin
      next_acc  = 9'h000;
      next_tick = 1'b1;
    end
    else if (sum >= limit)
    begin
      next_acc  = sum - limit;
      next_tick = 1'b1;
    end
    else
    begin
      next_acc  = sum;
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc  <= 9'h000;
      tick <= 1'b0;
    end
    else
    begin
      acc  <= next_acc;
      tick <= next_tick;
    end
  end

endmodule
`default_nettype wire

// ==== verif/umc_line_dev.sv ====
// Far-side line device model driving the external clock pins
`timescale 1ns/1ns
`default_nettype none

module umc_line_dev
(
  // Clock
  input  wire logic       core_clk,
  // Control: run gives a 1x clock, else pins rest at lvl
  input  wire logic       run,
  input  wire logic [2:0] lvl,
  // Pins
  output var  logic       ring_pin,
  output var  logic       dsr_pin,
  output var  logic       dtr_pin
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;

  always_comb next_cnt = run ? cnt + 3'h1 : 3'h0;
  always_ff @(posedge core_clk) cnt <= next_cnt;
  // Clock stands still outside frames
  assign ring_pin = run ? cnt[2] : lvl[0];
  assign dtr_pin  = run ? ~cnt[2] : lvl[1];
  assign dsr_pin  = run ? cnt[1] : lvl[2];
endmodule
`default_nettype wire

// ==== verif/umc_mode_cfg_props.sv ====
// Port-level assertions for the mode and clock block
`timescale 1ns/1ns
`default_nettype none

module umc_mode_cfg_chk
  import umc_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Watched signals
  input  wire logic         fifo_depth_select_pin,
  input  wire umc_mode_t    mode,
  input  wire logic [7:0]   fifo_depth,
  input  wire logic         feat_750,
  input  wire logic         feat_enh,
  input  wire logic         feat_950,
  input  wire logic         trig_from_regs,
  input  wire logic [1:0]   fifo_trig_sel,
  input  wire logic         baud_tick,
  input  wire logic [4:0]   samples_per_bit,
  input  wire umc_clk_src_t tx_clk_src,
  input  wire umc_clk_src_t rx_clk_src,
  input  wire logic         tx_ext_clk,
  input  wire logic         rx_ext_clk
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_byte_depth: assert property (mode == UMC_MODE_BYTE |->
    fifo_depth == 8'h01) else $error("byte mode depth wrong");
  a_basic_depth: assert property (mode == UMC_MODE_BASIC |->
    fifo_depth == 8'h10 && !$past(fifo_depth_select_pin, 2))
    else $error("basic mode depth wrong");
  a_deep_depth: assert property (mode inside {UMC_MODE_EXT_PIN,
    UMC_MODE_750, UMC_MODE_ENH} |-> fifo_depth == 8'h80)
    else $error("deep mode depth wrong");
  a_reset_state: assert property ($rose(rstn) |->
    mode == UMC_MODE_BYTE && samples_per_bit == 5'h10)
    else $error("state after reset wrong");
  a_750_no_enh: assert property (feat_750 |-> !feat_enh)
    else $error("750 extras with enhanced mode");
  a_950_needs_enh: assert property (feat_950 |-> feat_enh)
    else $error("950 features without enhanced mode");
  a_trig_ignore_fcr: assert property (trig_from_regs |->
    fifo_trig_sel == 2'h0) else $error("fifo trigger bits used");
  a_sample_range: assert property (
    samples_per_bit inside {[5'h04:5'h10]})
    else $error("sample count out of range");
  a_int_clk_quiet: assert property (
    (tx_clk_src == UMC_CLK_INTERNAL |-> !tx_ext_clk) and
    (rx_clk_src == UMC_CLK_INTERNAL |-> !rx_ext_clk))
    else $error("external clock seen while internal");
  a_depth_track: assert property ($changed(fifo_depth) |->
    $changed(mode)) else $error("depth moved without mode");

  c_750: cover property (mode == UMC_MODE_750);
  c_enh: cover property (mode == UMC_MODE_ENH);
  c_tick: cover property (baud_tick);
  c_trig: cover property (trig_from_regs);
endmodule

bind umc_mode_cfg umc_mode_cfg_chk u_chk (.core_clk, .rstn,
  .fifo_depth_select_pin, .mode, .fifo_depth, .feat_750, .feat_enh,
  .feat_950, .trig_from_regs, .fifo_trig_sel, .baud_tick,
  .samples_per_bit, .tx_clk_src, .rx_clk_src, .tx_ext_clk, .rx_ext_clk);
`default_nettype wire

// ==== verif/umc_mode_cfg_tb.sv ====
// Self-checking bench for the mode and clock block
`timescale 1ns/1ns
`default_nettype none

module umc_mode_cfg_tb;
  import umc_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0, lvl = 3'h0;
  logic [7:0] reg_wdata = 8'h00, rxf = 8'h00, txf = 8'h00, r, p;
  logic pin = 1'b0, run = 1'b0, saw;
  logic ring, dsr, dtr, trg, rxd, txd, r485, dsrf, nine, srst, tick;
  logic txe, rxe;
  logic [7:0] rxtrig;
  logic [7:0] reg_rdata, depth;
  logic [4:0] samp;
  logic [31:0] seed;
  umc_mode_t mode;
  umc_clk_src_t txs, rxs;
  int bad_count = 0, cmp_count = 0, n;

  always #50 core_clk = ~core_clk;

  umc_line_dev u_dev (.core_clk, .run, .lvl, .ring_pin(ring),
    .dsr_pin(dsr), .dtr_pin(dtr));

  umc_mode_cfg uut (.core_clk, .rstn, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .fifo_depth_select_pin(pin),
    .ring_indicate_input(ring), .dsr_input(dsr), .dtr_input(dtr),
    .rx_fill_level(rxf), .tx_fill_level(txf), .flow_state(seed[15:8]),
    .mode, .fifo_depth(depth), .feat_750(), .feat_enh(), .feat_950(),
    .trig_from_regs(trg), .rx_trigger_level(rxtrig), .tx_trigger_level(),
    .flow_low_threshold(), .flow_high_threshold(), .fifo_trig_sel(),
    .tx_disable(txd), .rx_disable(rxd), .rs485_enable(r485),
    .dsr_flow_enable(dsrf), .nine_bit_enable(nine), .soft_reset(srst),
    .baud_tick(tick), .samples_per_bit(samp), .tx_clk_src(txs),
    .rx_clk_src(rxs), .tx_ext_clk(txe), .rx_ext_clk(rxe));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // c = {pin, enhanced, depth bit, fifo enable}
  function automatic logic [7:0] exp_depth(input logic [3:0] c);
    if (!c[0])
      return 8'h01;
    return (c[3:1] != 3'h0) ? 8'h80 : 8'h10;
  endfunction

  function automatic logic [7:0] exp_samp(input logic [3:0] v);
    return (v < 4'h4) ? 8'h10 : {4'h0, v};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic st;
    @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic iw(input logic [7:0] i, input logic [7:0] d);
    wr(3'h7, i);
    wr(3'h0, d);
  endtask

  task automatic ir(input logic [7:0] i, output logic [7:0] d);
    wr(3'h7, i);
    rd(3'h0, d);
  endtask

  // Cycles from the first to the ninth tick: 8M+N
  task automatic span(output int m);
    int k;
    m = 0;
    k = 0;
    while (k < 9 && m < 400)
    begin
      st();
      if (k > 0)
        m++;
      if (tick === 1'b1)
        k++;
    end
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #3000000;
    bad_count++;
    summarize();
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    seed = 32'h73b25f4a;
    do_reset();
    st();
    chk(depth, 8'h01);
    chk({3'h0, samp}, 8'h10);
    span(n);
    chk(n[7:0], 8'h20);
    for (int i = 0; i < 16; i++)
    begin
      do_reset();
      pin <= i[3];
      if (i[2])
      begin
        wr(3'h3, 8'h3f);
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'h10);
      end
      wr(3'h3, 8'h80);
      wr(3'h2, {2'h0, i[1], 4'h0, i[0]});
      wr(3'h3, 8'h00);
      st();
      chk(depth, exp_depth(i[3:0]));
    end
    do_reset();
    pin <= 1'b0;
    wr(3'h2, 8'h01);
    st();
    chk(depth, 8'h10);
    wr(3'h2, 8'h21);
    st();
    chk(depth, 8'h10);
    pin <= 1'b1;
    st();
    st();
    chk(depth, 8'h80);
    pin <= 1'b0;
    wr(3'h3, 8'h80);
    wr(3'h2, 8'h21);
    wr(3'h3, 8'h00);
    st();
    chk({5'h0, mode}, {5'h0, UMC_MODE_750});
    wr(3'h2, 8'h20);
    pin <= 1'b1;
    st();
    chk(depth, 8'h01);
    iw(8'h00, 8'hc0);
    ir(8'h03, r);
    chk(r, 8'h00);
    for (int v = 0; v < 16; v++)
    begin
      iw(8'h03, v[7:0]);
      st();
      chk({3'h0, samp}, exp_samp(v[3:0]));
      ir(8'h03, r);
      chk(r, v[7:0]);
    end
    for (int j = 0; j < 4; j++)
    begin
      seed = lfsr(seed);
      p = (j == 0) ? 8'h08 : (j == 1) ? 8'hff : (seed[7:0] | 8'h08);
      iw(8'h01, p);
      span(n);
      chk(n[7:0], p);
    end
    iw(8'h02, 8'h01);
    lvl <= 3'b001;
    repeat (4) st();
    chk({6'h0, txs}, {6'h0, UMC_CLK_RING});
    chk({7'h0, txe}, 8'h01);
    iw(8'h02, 8'h06);
    lvl <= 3'b110;
    repeat (4) st();
    chk({4'h0, txs, rxs}, {4'h0, UMC_CLK_READY, UMC_CLK_DSR});
    chk({6'h0, txe, rxe}, 8'h03);
    run <= 1'b1;
    saw = 1'b0;
    repeat (12)
    begin
      st();
      saw |= (txe === 1'b0);
    end
    run <= 1'b0;
    chk({7'h0, saw}, 8'h01);
    iw(8'h02, 8'h00);
    repeat (4) st();
    chk({7'h0, txe}, 8'h00);
    wr(3'h3, 8'h3f);
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h10);
    wr(3'h3, 8'h00);
    wr(3'h2, 8'h01);
    iw(8'h00, 8'hfb);
    st();
    chk({3'h0, trg, rxd, txd, dsrf, r485}, 8'h1f);
    iw(8'h00, 8'hc0);
    st();
    chk({3'h0, trg, rxd, txd, dsrf, r485}, 8'h00);
    seed = lfsr(seed);
    rxf <= seed[7:0];
    txf <= seed[15:8];
    ir(8'h0d, r);
    chk(r, seed[7:0]);
    ir(8'h0e, r);
    chk(r, seed[15:8]);
    ir(8'h0f, r);
    chk(r, seed[15:8]);
    seed = lfsr(seed);
    iw(8'h05, seed[7:0]);
    st();
    chk(rxtrig, seed[7:0]);
    rd(3'h1, r);
    chk(r, 8'h00);
    iw(8'h0c, 8'h01);
    st();
    chk({7'h0, nine}, 8'h01);
    iw(8'h0c, 8'h00);
    #1;
    chk({7'h0, srst}, 8'h01);
    st();
    chk({7'h0, srst}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
